// >>> irq_host_model.sv
// Host side of the two interrupt pins: pull-ups on both wires and an
// optional host driver per wire, so the device input path can be exercised.
// Assumes the device splits each pin into out, oe and in.
`timescale 1ns/10ps

module irq_host_model (
  // Device drive of pin a
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  // Device drive of pin b
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  // Host drive, used only while the device output is off
  input wire logic host_a_en,
  input wire logic host_a_lvl,
  input wire logic host_b_en,
  input wire logic host_b_lvl,
  // Resolved wire levels
  output logic wire_a,
  output logic wire_b
);
  //////////////////////////////////////////////////////////////////////////////
  // Wire resolution; pull-up wins when nobody drives, as open drain needs
  assign wire_a = pin_a_oe ? pin_a_out : (host_a_en ? host_a_lvl : 1'h1);
  assign wire_b = pin_b_oe ? pin_b_out : (host_b_en ? host_b_lvl : 1'h1);
endmodule

// >>> irq_pin_defines.svh
// Register indices, field positions and reset values of the interrupt pin block.
// Assumes APB with 32-bit data; byte address is four times each index.
`ifndef IRQ_PIN_DEFINES_SVH
`define IRQ_PIN_DEFINES_SVH

// Register indices (byte address = index * 4)
`define IDX_ERR_MASK 8'h52
`define IDX_PIN_A_CFG 8'h53
`define IDX_PIN_B_CFG 8'h54
`define IDX_HOLD_MODE 8'h55
`define IDX_ROUTE 8'h58
`define IDX_ERR_STATUS 8'h60
`define IDX_EVT_STATUS 8'h61
`define IDX_EVT_MASK 8'h62

// Reset values
`define RST_ERR_MASK 8'h00
`define RST_PIN_CFG 8'h00
`define RST_HOLD_MODE 8'h00
`define RST_ROUTE 8'h00
`define RST_EVT 3'h0

// Writable bits of each register
`define ERR_SRC_VALID 8'hDF
`define PIN_CFG_VALID 8'h1E
`define HOLD_MODE_VALID 8'h01
`define ROUTE_VALID 8'h88

// Field positions
`define BIT_FATAL 0
`define BIT_FIFO 6
`define BIT_AUX 7
`define BIT_ROUTE_A 3
`define BIT_ROUTE_B 7
`define BIT_HOLD 0
`define EVT_ERR 0
`define EVT_PIN_A 1
`define EVT_PIN_B 2

`endif

// >>> irq_pin_driver.sv
// Output stage and input path of one interrupt pin.
// Assumes pin input is synchronous to clk; the wire level is resolved outside.
`timescale 1ns/10ps
`include "irq_pin_defines.svh"

module irq_pin_driver
  import irq_pin_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic asserted,
  input pin_cfg_t cfg,
  // Pin
  input wire logic pin_in,
  output pin_drive_t drive,
  output logic in_level
);

  logic level_next;

  // Polarity: active high passes the request, active low inverts it
  assign level_next = cfg.active_high ? asserted : ~asserted;

  ////////////////////////////////////////////////////////////////////////////
  // drive style select
  // Open drain only ever pulls low, so a high level releases the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive <= '0;
    end else begin
      drive.out <= cfg.drain_only_drive ? 1'b0 : level_next;
      drive.oe <= cfg.out_en & (cfg.drain_only_drive ? ~level_next : 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_level <= 1'b0;
    end else begin
      in_level <= cfg.in_en & pin_in;
    end
  end

endmodule

// >>> irq_pin_output_control.sv
// Error interrupt masking, latch mode and electrical control of two
// interrupt pins, with an APB register slave and a level interrupt.
// Assumes err_src and pin inputs are synchronous to clk; pins resolved outside.
`timescale 1ns/10ps
`include "irq_pin_defines.svh"

module irq_pin_output_control
  import irq_pin_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal error sources
  input wire logic [7:0] err_src,
  // Pin a
  input wire logic irq_pin_a_in,
  output logic irq_pin_a_out,
  output logic irq_pin_a_oe,
  // Pin b
  input wire logic irq_pin_b_in,
  output logic irq_pin_b_out,
  output logic irq_pin_b_oe,
  // Interrupt to the local processor
  output logic irq
);

  logic [7:0] err_mask_reg;
  pin_cfg_t pin_a_cfg_reg;
  pin_cfg_t pin_b_cfg_reg;
  logic [7:0] hold_mode_reg;
  logic [7:0] route_reg;
  logic [2:0] evt_status_reg;
  logic [2:0] evt_mask_reg;
  logic err_irq_reg;
  logic err_irq_prev_reg;
  logic pin_a_seen_prev_reg;
  logic pin_b_seen_prev_reg;
  logic [31:0] prdata_next;
  logic hit;
  logic [7:0] idx;
  logic access_done;
  logic wr_en;
  logic rd_status;
  logic masked_err;
  logic latch_mode;
  logic [2:0] evt_set;
  logic pin_a_seen;
  logic pin_b_seen;
  pin_drive_t pin_a_drive;
  pin_drive_t pin_b_drive;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign idx = paddr[9:2];
  assign access_done = psel & penable & pready;
  assign wr_en = access_done & pwrite & pstrb[0] & hit;
  assign rd_status = access_done & ~pwrite & (idx == `IDX_ERR_STATUS);

  // Address hit and read mux; upper address bits must be zero
  always_comb begin
    hit = (paddr[ADDR_W-1:10] == '0);
    prdata_next = 32'h0000_0000;
    case (idx)
      `IDX_ERR_MASK: prdata_next[7:0] = err_mask_reg;
      `IDX_PIN_A_CFG: prdata_next[7:0] = pin_a_cfg_reg;
      `IDX_PIN_B_CFG: prdata_next[7:0] = pin_b_cfg_reg;
      `IDX_HOLD_MODE: prdata_next[7:0] = hold_mode_reg;
      `IDX_ROUTE: prdata_next[7:0] = route_reg;
      `IDX_ERR_STATUS: prdata_next[2:0] = {pin_b_seen, pin_a_seen, err_irq_reg};
      `IDX_EVT_STATUS: prdata_next[2:0] = evt_status_reg;
      `IDX_EVT_MASK: prdata_next[2:0] = evt_mask_reg;
      default: hit = 1'b0;
    endcase
  end

  // One wait-free answer: ready rises in the cycle after setup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~hit;
      if (psel & ~penable & ~pready) begin
        prdata <= (hit & ~pwrite) ? prdata_next : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; reserved bits are dropped on write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_mask_reg <= `RST_ERR_MASK;
      pin_a_cfg_reg <= `RST_PIN_CFG;
      pin_b_cfg_reg <= `RST_PIN_CFG;
      hold_mode_reg <= `RST_HOLD_MODE;
      route_reg <= `RST_ROUTE;
      evt_mask_reg <= `RST_EVT;
    end else if (wr_en) begin
      case (idx)
        `IDX_ERR_MASK: err_mask_reg <= pwdata[7:0] & `ERR_SRC_VALID;
        `IDX_PIN_A_CFG: pin_a_cfg_reg <= pin_cfg_t'(pwdata[7:0] & `PIN_CFG_VALID);
        `IDX_PIN_B_CFG: pin_b_cfg_reg <= pin_cfg_t'(pwdata[7:0] & `PIN_CFG_VALID);
        `IDX_HOLD_MODE: hold_mode_reg <= pwdata[7:0] & `HOLD_MODE_VALID;
        `IDX_ROUTE: route_reg <= pwdata[7:0] & `ROUTE_VALID;
        `IDX_EVT_MASK: evt_mask_reg <= pwdata[2:0];
        default: evt_mask_reg <= evt_mask_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // masked error reduction
  // per-source gating
  // Bit 5 has no source; the valid mask keeps it out
  assign masked_err = |(err_src & err_mask_reg & `ERR_SRC_VALID);

  assign latch_mode = hold_mode_reg[`BIT_HOLD];

  // latch until status read
  // A new error in the clearing cycle wins over the read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_irq_reg <= 1'b0;
    end else if (latch_mode) begin
      err_irq_reg <= masked_err | (err_irq_reg & ~rd_status);
    end else begin
      err_irq_reg <= masked_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin a stage
  // routing bit 3 to pin a
  irq_pin_driver pin_a_stage (
    .clk(clk),
    .rst(rst),
    .asserted(err_irq_reg & route_reg[`BIT_ROUTE_A]),
    .cfg(pin_a_cfg_reg),
    .pin_in(irq_pin_a_in),
    .drive(pin_a_drive),
    .in_level(pin_a_seen)
  );

  // routing bit 7 to pin b
  irq_pin_driver pin_b_stage (
    .clk(clk),
    .rst(rst),
    .asserted(err_irq_reg & route_reg[`BIT_ROUTE_B]),
    .cfg(pin_b_cfg_reg),
    .pin_in(irq_pin_b_in),
    .drive(pin_b_drive),
    .in_level(pin_b_seen)
  );

  assign irq_pin_a_out = pin_a_drive.out;
  assign irq_pin_a_oe = pin_a_drive.oe;
  assign irq_pin_b_out = pin_b_drive.out;
  assign irq_pin_b_oe = pin_b_drive.oe;

  ////////////////////////////////////////////////////////////////////////////
  // Rising-edge detectors for the event status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_irq_prev_reg <= 1'b0;
      pin_a_seen_prev_reg <= 1'b0;
      pin_b_seen_prev_reg <= 1'b0;
    end else begin
      err_irq_prev_reg <= err_irq_reg;
      pin_a_seen_prev_reg <= pin_a_seen;
      pin_b_seen_prev_reg <= pin_b_seen;
    end
  end

  assign evt_set[`EVT_ERR] = err_irq_reg & ~err_irq_prev_reg;
  assign evt_set[`EVT_PIN_A] = pin_a_seen & ~pin_a_seen_prev_reg;
  assign evt_set[`EVT_PIN_B] = pin_b_seen & ~pin_b_seen_prev_reg;

  // Sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_status_reg <= `RST_EVT;
    end else if (wr_en && idx == `IDX_EVT_STATUS) begin
      evt_status_reg <= (evt_status_reg & ~pwdata[2:0]) | evt_set;
    end else begin
      evt_status_reg <= evt_status_reg | evt_set;
    end
  end

  // Level interrupt from the registered status, this cycle's event sets and the mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((evt_status_reg | evt_set) & evt_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_mask_blocks_all: assert property (
    (!latch_mode && (err_src & err_mask_reg) == 8'h00) |=> !err_irq_reg)
    else $error("unmasked-free error still raised interrupt");

  chk_fatal_gate: assert property (
    (err_mask_reg[`BIT_FATAL] && err_src[`BIT_FATAL]) |=> err_irq_reg)
    else $error("fatal error not gated into interrupt");

  chk_internal_gate: assert property (
    (|(err_mask_reg[4:1] & err_src[4:1])) |=> err_irq_reg)
    else $error("internal error not gated into interrupt");

  chk_fifo_gate: assert property (
    (err_mask_reg[`BIT_FIFO] && err_src[`BIT_FIFO]) |=> err_irq_reg)
    else $error("fifo error not gated into interrupt");

  chk_aux_gate: assert property (
    (err_mask_reg[`BIT_AUX] && err_src[`BIT_AUX]) |=> err_irq_reg)
    else $error("aux error not gated into interrupt");

  chk_pin_a_polarity: assert property (
    (!pin_a_cfg_reg.drain_only_drive && route_reg[`BIT_ROUTE_A])
      |=> irq_pin_a_out == ($past(err_irq_reg) ~^ $past(pin_a_cfg_reg.active_high)))
    else $error("pin a level does not follow polarity");

  chk_pin_a_drain: assert property (
    pin_a_cfg_reg.drain_only_drive |=> !irq_pin_a_out)
    else $error("pin a open drain drove high");

  chk_pin_a_oe_off: assert property (
    !pin_a_cfg_reg.out_en |=> !irq_pin_a_oe)
    else $error("pin a driven while output disabled");

  chk_pin_a_input_off: assert property (
    !pin_a_cfg_reg.in_en |=> !pin_a_seen)
    else $error("pin a input seen while disabled");

  chk_pin_b_polarity: assert property (
    (!pin_b_cfg_reg.drain_only_drive && route_reg[`BIT_ROUTE_B])
      |=> irq_pin_b_out == ($past(err_irq_reg) ~^ $past(pin_b_cfg_reg.active_high)))
    else $error("pin b level does not follow polarity");

  chk_pin_b_drain: assert property (
    (pin_b_cfg_reg.drain_only_drive && pin_b_cfg_reg.out_en)
      |=> (irq_pin_b_oe == 1'b0 || irq_pin_b_out == 1'b0))
    else $error("pin b open drain drove high");

  chk_pin_b_oe_off: assert property (
    !pin_b_cfg_reg.out_en |=> !irq_pin_b_oe)
    else $error("pin b driven while output disabled");

  chk_pin_b_input_off: assert property (
    !pin_b_cfg_reg.in_en |=> !pin_b_seen)
    else $error("pin b input seen while disabled");

  chk_nonlatch_follows: assert property (
    (!latch_mode && !masked_err && err_irq_reg) |=> !err_irq_reg)
    else $error("non-latched interrupt did not drop");

  chk_latch_holds: assert property (
    (latch_mode && err_irq_reg && !rd_status) [*2] |-> ##1 err_irq_reg)
    else $error("latched interrupt dropped before status read");

  chk_route_a_off: assert property (
    (!route_reg[`BIT_ROUTE_A] && pin_a_cfg_reg.out_en && !pin_a_cfg_reg.drain_only_drive)
      |=> irq_pin_a_out == !$past(pin_a_cfg_reg.active_high))
    else $error("unrouted error reached pin a");

  chk_route_b_off: assert property (
    (!route_reg[`BIT_ROUTE_B] && !pin_b_cfg_reg.drain_only_drive)
      |=> irq_pin_b_out == !$past(pin_b_cfg_reg.active_high))
    else $error("unrouted error reached pin b");

  chk_latch_release: assert property (
    (latch_mode && rd_status && !masked_err) |=> !err_irq_reg)
    else $error("latched interrupt kept after status read");

  chk_pin_a_oe_on: assert property (
    (pin_a_cfg_reg.out_en && !pin_a_cfg_reg.drain_only_drive) |=> irq_pin_a_oe)
    else $error("pin a push-pull output not enabled");

  chk_pin_b_oe_on: assert property (
    (pin_b_cfg_reg.out_en && !pin_b_cfg_reg.drain_only_drive) |=> irq_pin_b_oe)
    else $error("pin b push-pull output not enabled");

  chk_pin_a_input_on: assert property (
    (pin_a_cfg_reg.in_en && irq_pin_a_in) |=> pin_a_seen)
    else $error("pin a input not seen while enabled");

  chk_pin_b_input_on: assert property (
    (pin_b_cfg_reg.in_en && irq_pin_b_in) |=> pin_b_seen)
    else $error("pin b input not seen while enabled");

  chk_ready_after_setup: assert property (
    (psel && !penable) |=> pready)
    else $error("no ready after setup cycle");

  chk_unmapped_error: assert property (
    (psel && !penable && !hit) |=> pslverr)
    else $error("unmapped access gave no slave error");

  chk_event_set_wins: assert property (
    evt_set[`EVT_ERR] |=> evt_status_reg[`EVT_ERR])
    else $error("error event lost in status");

  chk_irq_level: assert property (
    (|(evt_status_reg & evt_mask_reg)) |=> irq)
    else $error("masked event did not raise interrupt");

  cov_latched_clear: cover property (latch_mode && err_irq_reg && rd_status);
  cov_evt_clear: cover property (wr_en && idx == `IDX_EVT_STATUS);
  cov_pin_a_assert: cover property (irq_pin_a_oe && route_reg[`BIT_ROUTE_A] && err_irq_reg);
  cov_irq_raised: cover property (!irq ##1 irq);
  cov_unmapped: cover property (pready && pslverr);

endmodule

// >>> irq_pin_pkg.sv
// Types shared by the interrupt pin block and its pin driver.
// Assumes the defines header supplies all numeric constants.
package irq_pin_pkg;

  // Electrical configuration of one interrupt pin
  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic in_en;
    logic out_en;
    logic drain_only_drive;
    logic active_high;
    logic rsvd_lo;
  } pin_cfg_t;

  // Two-signal drive view (out, oe) of one two-way pin
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage

// >>> testbench.sv
// Self-checking bench for the interrupt pin output control block.
// Assumes the host model resolves both pin wires and feeds them back.
`timescale 1ns/10ps
`include "irq_pin_defines.svh"

module testbench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, a_out, a_oe, b_out, b_oe, irq, wire_a, wire_b;
  logic [7:0] err_src = 8'h00;
  logic ha_en = 1'h0;
  logic hb_en = 1'h0;
  logic h_lvl = 1'h0;
  int mismatches = 0;
  int compares = 0;
  localparam logic [7:0] UNMAPPED = 8'h70;
  localparam logic [7:0] MAPPED [8] = '{`IDX_ERR_MASK, `IDX_PIN_A_CFG, `IDX_PIN_B_CFG,
    `IDX_HOLD_MODE, `IDX_ROUTE, `IDX_ERR_STATUS, `IDX_EVT_STATUS, `IDX_EVT_MASK};

  //////////////////////////////////////////////////////////////////////////////
  // Clock and reset
  always #50 clk = ~clk;

  irq_pin_output_control dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .err_src(err_src), .irq_pin_a_in(wire_a),
    .irq_pin_a_out(a_out), .irq_pin_a_oe(a_oe), .irq_pin_b_in(wire_b),
    .irq_pin_b_out(b_out), .irq_pin_b_oe(b_oe), .irq(irq));

  irq_host_model host (.pin_a_out(a_out), .pin_a_oe(a_oe), .pin_b_out(b_out),
    .pin_b_oe(b_oe), .host_a_en(ha_en), .host_a_lvl(h_lvl), .host_b_en(hb_en),
    .host_b_lvl(h_lvl), .wire_a(wire_a), .wire_b(wire_b));

  //////////////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic regck(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic pinck(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // APB master; waits on pready at rising edges, the watchdog bounds a hang
  task automatic xfer(input logic is_wr, input logic [7:0] i, input logic [7:0] v,
      output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= is_wr;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, v};
    @(posedge clk);
    penable <= 1'h1;
    // Values read here are those sampled at this edge
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic [31:0] d;
    logic r;
    xfer(1'h1, i, v, d, r);
  endtask

  task automatic rdchk(input logic [7:0] i, input logic [31:0] e, input logic ee);
    logic [31:0] d;
    logic r;
    xfer(1'h0, i, 8'h00, d, r);
    regck("read data", e, d);
    pinck("slave error", ee, r);
  endtask

  // Error path takes two edges; two spare edges of margin
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic src(input logic [7:0] v);
    @(posedge clk);
    err_src <= v;
    settle();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic rw(input logic [7:0] i, input logic [7:0] valid);
    wr(i, 8'hFF);
    rdchk(i, {24'h0, valid}, 1'h0);
    wr(i, 8'h00);
  endtask

  task automatic gate(input int b);
    wr(`IDX_ERR_MASK, 8'h01 << b);
    src(~(8'h01 << b));
    pinck("masked source", 1'h0, wire_a);
    src(8'h01 << b);
    pinck("unmasked source", 1'h1, wire_a);
    src(8'h00);
  endtask

  task automatic pc(input logic b, input logic [7:0] c, input logic s, input logic w,
      input logic o);
    wr(b ? `IDX_PIN_B_CFG : `IDX_PIN_A_CFG, c);
    src({7'h0, s});
    pinck("pin wire", w, b ? wire_b : wire_a);
    pinck("pin enable", o, b ? b_oe : a_oe);
  endtask

  task automatic elec(input logic b);
    pc(b, 8'h08, 1'h0, 1'h1, 1'h1);
    pc(b, 8'h08, 1'h1, 1'h0, 1'h1);
    pc(b, 8'h0A, 1'h1, 1'h1, 1'h1);
    pc(b, 8'h0C, 1'h0, 1'h1, 1'h0);
    pc(b, 8'h0C, 1'h1, 1'h0, 1'h1);
    pc(b, 8'h0E, 1'h0, 1'h0, 1'h1);
    pc(b, 8'h0E, 1'h1, 1'h1, 1'h0);
    pc(b, 8'h02, 1'h1, 1'h1, 1'h0);
    wr(b ? `IDX_PIN_B_CFG : `IDX_PIN_A_CFG, 8'h00);
  endtask

  // Host drives the wire only while the device output is disabled
  task automatic hin(input logic b, input logic [7:0] c, input logic v);
    wr(b ? `IDX_PIN_B_CFG : `IDX_PIN_A_CFG, c);
    @(posedge clk);
    ha_en <= !b;
    hb_en <= b;
    h_lvl <= v;
    settle();
    rdchk(`IDX_ERR_STATUS, (c[4] && v) ? (b ? 32'h4 : 32'h2) : 32'h0, 1'h0);
    @(posedge clk);
    ha_en <= 1'h0;
    hb_en <= 1'h0;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    foreach (MAPPED[k]) rdchk(MAPPED[k], 32'h0, 1'h0);
    rdchk(UNMAPPED, 32'h0, 1'h1);
    rw(`IDX_ERR_MASK, `ERR_SRC_VALID);
    rw(`IDX_PIN_A_CFG, `PIN_CFG_VALID);
    rw(`IDX_PIN_B_CFG, `PIN_CFG_VALID);
    rw(`IDX_HOLD_MODE, `HOLD_MODE_VALID);
    rw(`IDX_ROUTE, `ROUTE_VALID);
    $display("test registers done");
    wr(`IDX_PIN_A_CFG, 8'h0A);
    wr(`IDX_ROUTE, 8'h08);
    gate(0);
    gate(1);
    gate(2);
    gate(3);
    gate(4);
    gate(6);
    gate(7);
    // Fatal source stays unmasked for the pin tests below
    wr(`IDX_ERR_MASK, 8'h01);
    wr(`IDX_PIN_B_CFG, 8'h0A);
    wr(`IDX_ROUTE, 8'h80);
    src(8'h01);
    pinck("unrouted pin a", 1'h0, wire_a);
    pinck("routed pin b", 1'h1, wire_b);
    $display("test masking done");
    wr(`IDX_ROUTE, 8'h88);
    wr(`IDX_PIN_A_CFG, 8'h00);
    wr(`IDX_PIN_B_CFG, 8'h00);
    elec(1'h0);
    elec(1'h1);
    $display("test electrical done");
    src(8'h00);
    hin(1'h0, 8'h10, 1'h0);
    hin(1'h0, 8'h10, 1'h1);
    hin(1'h0, 8'h00, 1'h1);
    hin(1'h1, 8'h10, 1'h1);
    hin(1'h1, 8'h00, 1'h1);
    $display("test input path done");
    wr(`IDX_PIN_A_CFG, 8'h0A);
    wr(`IDX_HOLD_MODE, 8'h01);
    src(8'h01);
    src(8'h00);
    pinck("latched pin", 1'h1, wire_a);
    rdchk(`IDX_ERR_STATUS, 32'h1, 1'h0);
    settle();
    pinck("released pin", 1'h0, wire_a);
    wr(`IDX_HOLD_MODE, 8'h00);
    src(8'h01);
    pinck("following pin", 1'h1, wire_a);
    src(8'h00);
    pinck("following pin", 1'h0, wire_a);
    $display("test latch done");
    // Sticky event, masked level interrupt, write-one clear
    wr(`IDX_EVT_STATUS, 8'h07);
    wr(`IDX_EVT_MASK, 8'h01);
    src(8'h01);
    src(8'h00);
    pinck("irq raised", 1'h1, irq);
    rdchk(`IDX_EVT_STATUS, 32'h1, 1'h0);
    wr(`IDX_EVT_STATUS, 8'h01);
    settle();
    pinck("irq cleared", 1'h0, irq);
    wr(`IDX_EVT_MASK, 8'h00);
    src(8'h01);
    src(8'h00);
    pinck("irq masked", 1'h0, irq);
    rdchk(`IDX_EVT_STATUS, 32'h1, 1'h0);
    $display("test interrupt done");
    close_out();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog; the run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
endmodule
